// >>> hw/rpfm_pkg.sv
// Package for the receiver pin function map: constants, modes and carrier structs
//
// Function
// RQ1: Code-division lanes: A-I, B-I, A-Q, B-Q
// RQ2: Wideband lanes: I msb, I msb-1, Q msb, Q msb-1
// RQ3: Parallel I word on channels four to seven
// RQ4: Parallel Q word on channels zero to three
// RQ5: Per-channel frame strobes; channel six frames parallel
// RQ6: Six-bit gain words, bit five most significant
// RQ7: Test bits 0-17 on gain c and port c
// RQ8: Test bits 18-35, clock, sync, flag placed
// RQ9: Each digital input port has own clock
// RQ10: Overrange flag accepted with each input sample
// RQ11: Second input port unused, not connected; the code still captures port d through u_cap_d
// RQ12: Host port: 16-bit data, 6-bit address, strobes
// RQ13: Format and test enable from configuration inputs
package rpfm_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int RPFM_NUM_CH = 8;
  localparam int RPFM_LANES = 4;
  localparam int RPFM_WORD_W = 16;
  localparam int RPFM_GAIN_W = 6;
  localparam int RPFM_TEST_W = 36;
  localparam int RPFM_ADDR_W = 6;
  localparam int RPFM_PAR_I_FIRST_CH = 4;
  localparam int RPFM_PAR_SYNC_CH = 6;

  // ****************************************
  // Test bus field positions
  // ****************************************
  localparam int RPFM_TB_GC_LO = 0;
  localparam int RPFM_TB_PORTC_LO = 2;
  localparam int RPFM_TB_GC_HI = 18;
  localparam int RPFM_TB_PORTD_LO = 20;
  localparam int RPFM_GAIN_SYNC_BIT = 0;
  localparam int RPFM_GAIN_CLK_BIT = 1;
  localparam int RPFM_GAIN_FLAG_BIT = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [5:0] RPFM_GAIN_RST = 6'h00;
  localparam logic [15:0] RPFM_WORD_RST = 16'h0000;

  // ****************************************
  // Output formats
  // ****************************************
  typedef enum logic [1:0] {
    RPFM_FMT_CODE_DIVISION = 2'b00,
    RPFM_FMT_WIDEBAND = 2'b01,
    RPFM_FMT_PARALLEL = 2'b10
  } rpfm_fmt_t;

  // One channel's serial bit pairs
  typedef struct packed {
    logic sub_a_i;
    logic sub_b_i;
    logic sub_a_q;
    logic sub_b_q;
  } rpfm_cd_bits_t;

  typedef struct packed {
    logic i_msb;
    logic i_msb_m1;
    logic q_msb;
    logic q_msb_m1;
  } rpfm_wb_bits_t;

  // One digital input sample with its overrange flag
  typedef struct packed {
    logic ovr;
    logic [15:0] data;
  } rpfm_sample_t;

  // Test bus word with its qualifiers
  typedef struct packed {
    logic flag;
    logic sync;
    logic clk;
    logic [35:0] data;
  } rpfm_test_t;

endpackage : rpfm_pkg

// >>> hw/rpfm_in_capture.sv
// Input capture for one external digital port: two-flop synchroniser into clk
`timescale 1ns/1ps
module rpfm_in_capture
  import rpfm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pin side
  input wire logic [15:0] pin_data,
  input wire logic pin_ovr,
  input wire logic pin_clk,
  // Core side
  output rpfm_sample_t sample,
  output logic sample_clk
);

  // ****************************************
  // Synchroniser
  // ****************************************
  rpfm_sample_t stage1;
  logic clk_stage1;
  logic clk_stage2;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '0;
      sample <= '0;
    end else begin
      stage1 <= '{ovr: pin_ovr, data: pin_data}; // RQ10
      sample <= stage1;
    end
  end

  // Port clock carried as a level; the core edge-detects after the second flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_stage1 <= 1'b0;
      clk_stage2 <= 1'b0;
    end else begin
      clk_stage1 <= pin_clk; // RQ9
      clk_stage2 <= clk_stage1;
    end
  end

  assign sample_clk = clk_stage2;

endmodule : rpfm_in_capture

// >>> hw/rpfm_top.sv
// Receiver pin function map: output lane mux, gain outputs, test bus sharing
`timescale 1ns/1ps
module rpfm_top
  import rpfm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration
  input wire rpfm_fmt_t out_format,
  input wire logic test_bus_enable,
  // Channel data from the downconverter channels
  input wire rpfm_cd_bits_t [7:0] cd_bits,
  input wire rpfm_wb_bits_t [7:0] wb_bits,
  input wire logic [7:0] chan_frame,
  input wire logic [15:0] par_i_word,
  input wire logic [15:0] par_q_word,
  input wire logic par_frame,
  // Gain control and test bus sources
  input wire logic [5:0] gain_c_word,
  input wire logic [5:0] gain_d_word,
  input wire logic [5:0] gain_conv_word,
  input wire rpfm_test_t test_word,
  // Serial output lanes and frame strobes
  output logic [7:0][3:0] rxout,
  output logic [7:0] rx_frame_out,
  // Gain pins
  output logic [5:0] gain_conv,
  output logic [5:0] gain_unused,
  output logic [5:0] gain_c,
  output logic [5:0] gain_d,
  // Digital input port c and d pins
  input wire logic [15:0] port_c_in,
  output logic [15:0] port_c_out,
  output logic port_c_oe,
  input wire logic port_c_ovr,
  input wire logic port_c_clk,
  input wire logic [15:0] port_d_in,
  output logic [15:0] port_d_out,
  output logic port_d_oe,
  input wire logic port_d_ovr,
  input wire logic port_d_clk,
  // Captured samples to the channels
  output rpfm_sample_t sample_c,
  output rpfm_sample_t sample_d,
  output logic sample_c_clk,
  output logic sample_d_clk,
  // Host register port
  input wire logic [15:0] host_d_in,
  output logic [15:0] host_d_out,
  output logic host_d_oe,
  input wire logic [5:0] host_addr,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_ce_n,
  input wire logic chip_reset_n,
  input wire logic [15:0] host_rdata,
  output logic host_wr_stb,
  output logic host_rd_stb,
  output logic [5:0] host_addr_q,
  output logic [15:0] host_wdata,
  output logic chip_reset_req
);

  // ****************************************
  // Lane selection
  // ****************************************
  function automatic logic [3:0] lane_word(input rpfm_fmt_t fmt, input rpfm_cd_bits_t cd,
                                           input rpfm_wb_bits_t wb, input logic [3:0] par);
    logic [3:0] res;
    res = 4'h0;
    case (fmt)
      RPFM_FMT_CODE_DIVISION: res = {cd.sub_a_i, cd.sub_b_i, cd.sub_a_q, cd.sub_b_q}; // RQ1
      RPFM_FMT_WIDEBAND: res = {wb.i_msb, wb.i_msb_m1, wb.q_msb, wb.q_msb_m1}; // RQ2
      RPFM_FMT_PARALLEL: res = {par[0], par[1], par[2], par[3]};
      default: res = 4'h0;
    endcase
    return res;
  endfunction : lane_word

  // Lane vector packs a as bit 3 down to d as bit 0
  genvar ch;
  generate
    for (ch = 0; ch < RPFM_NUM_CH; ch++) begin : g_lane
      logic [3:0] par_nib;
      if (ch >= RPFM_PAR_I_FIRST_CH) begin : g_i
        assign par_nib = par_i_word[(ch - RPFM_PAR_I_FIRST_CH) * 4 +: 4]; // RQ3
      end else begin : g_q
        assign par_nib = par_q_word[ch * 4 +: 4]; // RQ4
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          rxout[ch] <= 4'h0;
        end else begin
          rxout[ch] <= lane_word(out_format, cd_bits[ch], wb_bits[ch], par_nib); // RQ13
        end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          rx_frame_out[ch] <= 1'b0;
        end else if (out_format == RPFM_FMT_PARALLEL) begin
          rx_frame_out[ch] <= (ch == RPFM_PAR_SYNC_CH) ? par_frame : 1'b0; // RQ5
        end else begin
          rx_frame_out[ch] <= chan_frame[ch]; // RQ5
        end
      end
    end
  endgenerate

  // ****************************************
  // Gain outputs and test bus sharing
  // ****************************************
  logic [5:0] next_gain_c;
  logic [5:0] next_gain_d;

  always_comb begin
    next_gain_c = gain_c_word; // RQ6
    next_gain_d = gain_d_word; // RQ6
    if (test_bus_enable) begin
      next_gain_c[5:4] = {test_word.data[RPFM_TB_GC_LO + 1], test_word.data[RPFM_TB_GC_LO]}; // RQ7
      next_gain_c[3:2] = {test_word.data[RPFM_TB_GC_HI + 1], test_word.data[RPFM_TB_GC_HI]}; // RQ8
      next_gain_c[RPFM_GAIN_CLK_BIT] = test_word.clk; // RQ8
      next_gain_c[RPFM_GAIN_SYNC_BIT] = test_word.sync; // RQ8
      next_gain_d[RPFM_GAIN_FLAG_BIT] = test_word.flag; // RQ8
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gain_conv <= RPFM_GAIN_RST;
      gain_c <= RPFM_GAIN_RST;
      gain_d <= RPFM_GAIN_RST;
    end else begin
      gain_conv <= gain_conv_word; // RQ6
      gain_c <= next_gain_c;
      gain_d <= next_gain_d;
    end
  end

  // Unused second source carries nothing
  assign gain_unused = RPFM_GAIN_RST; // RQ6

  // Port pins turn to outputs only while the test bus owns them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_c_out <= RPFM_WORD_RST;
      port_d_out <= RPFM_WORD_RST;
      port_c_oe <= 1'b0;
      port_d_oe <= 1'b0;
    end else begin
      port_c_out <= test_word.data[RPFM_TB_PORTC_LO +: RPFM_WORD_W]; // RQ7
      port_d_out <= test_word.data[RPFM_TB_PORTD_LO +: RPFM_WORD_W]; // RQ8
      port_c_oe <= test_bus_enable; // RQ7
      port_d_oe <= test_bus_enable; // RQ8
    end
  end

  // ****************************************
  // Digital input ports; each port has its own capture
  // ****************************************
  rpfm_in_capture u_cap_c (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_data(port_c_in),
    .pin_ovr(port_c_ovr),
    .pin_clk(port_c_clk),
    .sample(sample_c),
    .sample_clk(sample_c_clk)
  ); // RQ11

  rpfm_in_capture u_cap_d (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_data(port_d_in),
    .pin_ovr(port_d_ovr),
    .pin_clk(port_d_clk),
    .sample(sample_d),
    .sample_clk(sample_d_clk)
  );

  // ****************************************
  // Host port: strobes synchronised, read pulses on the asserting edge, write pulses on release
  // ****************************************
  logic [2:0] strb_s1;
  logic [2:0] strb_s2;
  logic [2:0] strb_s3;
  logic [5:0] addr_s1;
  logic [15:0] data_s1;
  logic rst_s1;
  logic rst_s2;
  logic rd_active;
  logic wr_active;
  logic wr_prev;
  logic rd_prev;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strb_s1 <= 3'h7;
      strb_s2 <= 3'h7;
      strb_s3 <= 3'h7;
      addr_s1 <= 6'h00;
      data_s1 <= RPFM_WORD_RST;
      host_addr_q <= 6'h00;
      host_wdata <= RPFM_WORD_RST;
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
    end else begin
      strb_s1 <= {host_ce_n, host_rd_n, host_wr_n}; // RQ12
      strb_s2 <= strb_s1;
      strb_s3 <= strb_s2;
      addr_s1 <= host_addr;
      data_s1 <= host_d_in;
      host_addr_q <= addr_s1;
      host_wdata <= data_s1;
      rst_s1 <= chip_reset_n;
      rst_s2 <= rst_s1;
    end
  end

  assign wr_active = !strb_s2[2] && !strb_s2[0];
  assign rd_active = !strb_s2[2] && !strb_s2[1];
  assign wr_prev = !strb_s3[2] && !strb_s3[0];
  assign rd_prev = !strb_s3[2] && !strb_s3[1];
  assign chip_reset_req = !rst_s2; // RQ12

  // Write is taken on release so the data has settled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_wr_stb <= 1'b0;
      host_rd_stb <= 1'b0;
      host_d_oe <= 1'b0;
      host_d_out <= RPFM_WORD_RST;
    end else begin
      host_wr_stb <= wr_prev && !wr_active; // RQ12
      host_rd_stb <= rd_active && !rd_prev;
      host_d_oe <= rd_active; // RQ12
      host_d_out <= host_rdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence par_sel_s;
    out_format == RPFM_FMT_PARALLEL;
  endsequence

  // Host strobe steps as seen at the pins; the pulses land three edges after the last step
  sequence wr_seen_s;
    !host_ce_n && !host_wr_n;
  endsequence

  sequence wr_gone_s;
    host_ce_n || host_wr_n;
  endsequence

  sequence rd_seen_s;
    !host_ce_n && !host_rd_n;
  endsequence

  sequence rd_gone_s;
    host_ce_n || host_rd_n;
  endsequence

  lane_cd_map_a: assert property (@(posedge clk) disable iff (sys_rst)
    out_format == RPFM_FMT_CODE_DIVISION |=> rxout[0] == $past({cd_bits[0].sub_a_i, cd_bits[0].sub_b_i,
    cd_bits[0].sub_a_q, cd_bits[0].sub_b_q})) else $error("code division lanes wrong"); // RQ1
  lane_wb_map_a: assert property (@(posedge clk) disable iff (sys_rst)
    out_format == RPFM_FMT_WIDEBAND |=> rxout[5][3] == $past(wb_bits[5].i_msb)
    && rxout[5][0] == $past(wb_bits[5].q_msb_m1)) else $error("wideband lanes wrong"); // RQ2
  par_i_top_a: assert property (@(posedge clk) disable iff (sys_rst)
    par_sel_s |=> rxout[7][0] == $past(par_i_word[15]) && rxout[4][3] == $past(par_i_word[0]))
    else $error("parallel I placement wrong"); // RQ3
  par_q_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    par_sel_s |=> rxout[0][3] == $past(par_q_word[0]) && rxout[3][0] == $past(par_q_word[15]))
    else $error("parallel Q placement wrong"); // RQ4
  par_frame_a: assert property (@(posedge clk) disable iff (sys_rst)
    par_sel_s |=> rx_frame_out[6] == $past(par_frame)) else $error("parallel frame wrong"); // RQ5
  gain_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
    !test_bus_enable |=> gain_c == $past(gain_c_word) && gain_unused == 6'h00)
    else $error("gain word wrong"); // RQ6
  test_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    test_bus_enable |=> port_c_oe && port_c_out == $past(test_word.data[17:2])
    && gain_c[4] == $past(test_word.data[0])) else $error("test bus low half wrong"); // RQ7
  test_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    test_bus_enable |=> port_d_out == $past(test_word.data[35:20]) && gain_c[1] == $past(test_word.clk)
    && gain_d[5] == $past(test_word.flag)) else $error("test bus high half wrong"); // RQ8
  sample_lat_a: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |-> ##2 sample_c.ovr == $past(port_c_ovr, 2)) else $error("overrange lost"); // RQ10
  ser_frame_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
    out_format != RPFM_FMT_PARALLEL |=> rx_frame_out == $past(chan_frame)) else $error("serial frame wrong");
  par_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
    par_sel_s |=> rx_frame_out[5:0] == 6'h00 && !rx_frame_out[7]) else $error("idle parallel strobes set");
  gain_d_pass_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
    !test_bus_enable |=> gain_d == $past(gain_d_word) && gain_conv == $past(gain_conv_word)
    && !port_c_oe && !port_d_oe) else $error("gain d or port direction wrong");
  wr_pulse_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
    wr_seen_s ##1 wr_gone_s |-> ##3 host_wr_stb) else $error("write strobe missing");
  rd_pulse_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
    rd_gone_s ##1 rd_seen_s |-> ##3 host_rd_stb) else $error("read strobe missing");
  rd_drive_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
    rd_seen_s |-> ##3 host_d_oe && host_d_out == $past(host_rdata)) else $error("read data not driven");
  host_path_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
    1'b1 |-> ##2 host_addr_q == $past(host_addr, 2) && host_wdata == $past(host_d_in, 2))
    else $error("host address or data path wrong");
  chip_rst_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
    !chip_reset_n |-> ##2 chip_reset_req) else $error("chip reset request missing");

endmodule : rpfm_top

// >>> test/rpfm_bb_model.sv
// Baseband processor model that samples the output lanes and frame strobes
`timescale 1ns/1ps
module rpfm_bb_model
  import rpfm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Device outputs
  input wire rpfm_fmt_t out_format,
  input wire logic [7:0][3:0] rxout,
  input wire logic [7:0] rx_frame_out,
  // Observations
  output logic [15:0] frame_cnt,
  output logic [15:0] cap_i,
  output logic [15:0] cap_q
);
  // Serial frames are counted per cycle with any strobe high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_cnt <= '0;
    end else if (out_format != RPFM_FMT_PARALLEL && |rx_frame_out) begin
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end

  // Parallel words rebuilt from the lanes on the channel six strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_i <= '0;
      cap_q <= '0;
    end else if (out_format == RPFM_FMT_PARALLEL && rx_frame_out[6]) begin
      for (int k = 0; k < 16; k++) begin
        cap_i[k] <= rxout[4 + k / 4][3 - k % 4];
        cap_q[k] <= rxout[k / 4][3 - k % 4];
      end
    end
  end
endmodule : rpfm_bb_model

// >>> test/rpfm_top_tb_top.sv
// Self-checking testbench for the receiver pin function map
`timescale 1ns/1ps
module rpfm_top_tb_top;
  import rpfm_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  rpfm_fmt_t out_format = RPFM_FMT_CODE_DIVISION;
  logic test_bus_enable = 1'b0;
  rpfm_cd_bits_t [7:0] cd_bits = '0;
  rpfm_wb_bits_t [7:0] wb_bits = '0;
  logic [7:0] chan_frame = '0;
  logic [15:0] par_i_word = '0;
  logic [15:0] par_q_word = '0;
  logic par_frame = 1'b0;
  logic [5:0] gain_c_word = '0;
  logic [5:0] gain_d_word = '0;
  logic [5:0] gain_conv_word = '0;
  rpfm_test_t test_word = '0;
  logic [7:0][3:0] rxout;
  logic [7:0] rx_frame_out;
  logic [5:0] gain_conv, gain_unused, gain_c, gain_d;
  logic [15:0] pc_drv = '0;
  logic [15:0] pd_drv = '0;
  logic [15:0] hd_drv = '0;
  logic [15:0] port_c_in, port_c_out, port_d_in, port_d_out, host_d_in, host_d_out;
  logic port_c_oe, port_d_oe, host_d_oe, host_wr_stb, host_rd_stb, chip_reset_req;
  logic port_c_ovr = 1'b0;
  logic port_c_clk = 1'b0;
  logic port_d_ovr = 1'b0;
  logic port_d_clk = 1'b0;
  rpfm_sample_t sample_c, sample_d;
  logic sample_c_clk, sample_d_clk;
  logic [5:0] host_addr = '0;
  logic host_rd_n = 1'b1;
  logic host_wr_n = 1'b1;
  logic host_ce_n = 1'b1;
  logic chip_reset_n = 1'b1;
  logic [15:0] host_rdata = '0;
  logic [5:0] host_addr_q;
  logic [15:0] host_wdata;
  logic [15:0] frame_cnt, cap_i, cap_q;
  int fail_count = 0;
  int checks = 0;

  // Shared pins resolve from whoever drives them
  assign port_c_in = port_c_oe ? port_c_out : pc_drv;
  assign port_d_in = port_d_oe ? port_d_out : pd_drv;
  assign host_d_in = host_d_oe ? host_d_out : hd_drv;

  always #5 clk = ~clk;

  rpfm_top u_dut (.clk, .sys_rst, .out_format, .test_bus_enable, .cd_bits, .wb_bits, .chan_frame,
    .par_i_word, .par_q_word, .par_frame, .gain_c_word, .gain_d_word, .gain_conv_word, .test_word,
    .rxout, .rx_frame_out, .gain_conv, .gain_unused, .gain_c, .gain_d, .port_c_in, .port_c_out,
    .port_c_oe, .port_c_ovr, .port_c_clk, .port_d_in, .port_d_out, .port_d_oe, .port_d_ovr,
    .port_d_clk, .sample_c, .sample_d, .sample_c_clk, .sample_d_clk, .host_d_in, .host_d_out,
    .host_d_oe, .host_addr, .host_rd_n, .host_wr_n, .host_ce_n, .chip_reset_n, .host_rdata,
    .host_wr_stb, .host_rd_stb, .host_addr_q, .host_wdata, .chip_reset_req);

  rpfm_bb_model u_bb (.clk, .sys_rst, .out_format, .rxout, .rx_frame_out, .frame_cnt, .cap_i, .cap_q);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  // Bounded waits end the run when the bound is used up
  task automatic tmo(input int n);
    if (n >= 12) begin
      fail_count++;
      $display("ERROR %0t: wait bound used up", $time);
      complete_run();
    end
  endtask : tmo

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_serial();
    logic [15:0] f0;
    f0 = frame_cnt;
    for (int c = 0; c < 8; c++) begin
      cd_bits[c] = 4'(c + 5);
      wb_bits[c] = 4'(~c);
    end
    chan_frame = 8'h5a;
    step(1);
    for (int c = 0; c < 8; c++) begin
      chk(rxout[c], {cd_bits[c].sub_a_i, cd_bits[c].sub_b_i, cd_bits[c].sub_a_q, cd_bits[c].sub_b_q});
    end
    chk(rx_frame_out, 8'h5a);
    chan_frame = 8'h00;
    out_format = RPFM_FMT_WIDEBAND;
    step(1);
    chk(frame_cnt, f0 + 16'h0001);
    for (int c = 0; c < 8; c++) begin
      chk(rxout[c], {wb_bits[c].i_msb, wb_bits[c].i_msb_m1, wb_bits[c].q_msb, wb_bits[c].q_msb_m1});
    end
  endtask : t_serial

  task automatic t_parallel();
    out_format = RPFM_FMT_PARALLEL;
    par_i_word = 16'h1e6b;
    par_q_word = 16'hc3a5;
    par_frame = 1'b1;
    chan_frame = 8'hff;
    step(1);
    for (int k = 0; k < 16; k++) begin
      chk(rxout[4 + k / 4][3 - k % 4], par_i_word[k]);
      chk(rxout[k / 4][3 - k % 4], par_q_word[k]);
    end
    chk(rx_frame_out, 8'h40);
    par_frame = 1'b0;
    chan_frame = 8'h00;
    step(1);
    chk({cap_i, cap_q}, {par_i_word, par_q_word});
    chk(rx_frame_out, 8'h00);
    out_format = rpfm_fmt_t'(2'b11);
    step(1);
    chk(rxout, 32'h0000_0000);
  endtask : t_parallel

  task automatic t_gain_test();
    gain_c_word = 6'h25;
    gain_d_word = 6'h1a;
    gain_conv_word = 6'h33;
    step(1);
    chk({gain_c, gain_d, gain_conv, gain_unused}, {6'h25, 6'h1a, 6'h33, 6'h00});
    chk({port_c_oe, port_d_oe}, 2'h0);
    test_word = {1'b1, 1'b0, 1'b1, 36'h9_a5c3_1e7b};
    test_bus_enable = 1'b1;
    step(1);
    chk(gain_c, {test_word.data[1:0], test_word.data[19:18], 1'b1, 1'b0});
    chk(gain_d[5], 1'b1);
    chk({port_c_oe, port_c_out}, {1'b1, test_word.data[17:2]});
    chk({port_d_oe, port_d_out}, {1'b1, test_word.data[35:20]});
    test_bus_enable = 1'b0;
    step(1);
    chk({port_c_oe, port_d_oe}, 2'h0);
  endtask : t_gain_test

  task automatic t_inputs();
    pc_drv = 16'hbeef;
    port_c_ovr = 1'b1;
    port_c_clk = 1'b1;
    pd_drv = 16'h0f0f;
    port_d_ovr = 1'b0;
    port_d_clk = 1'b1;
    step(2);
    chk(sample_c, {1'b1, 16'hbeef});
    chk(sample_d, {1'b0, 16'h0f0f});
    chk({sample_c_clk, sample_d_clk}, 2'h3);
    port_c_clk = 1'b0;
    step(2);
    chk({sample_c_clk, sample_d_clk}, 2'h1);
  endtask : t_inputs

  task automatic t_host();
    int n;
    host_addr = 6'h2a;
    hd_drv = 16'h5a3c;
    host_ce_n = 1'b0;
    host_wr_n = 1'b0;
    step(4);
    host_ce_n = 1'b1;
    host_wr_n = 1'b1;
    for (n = 0; n < 12 && host_wr_stb !== 1'b1; n++) step(1);
    tmo(n);
    chk({host_addr_q, host_wdata}, {6'h2a, 16'h5a3c});
    host_rdata = 16'h7e81;
    host_ce_n = 1'b0;
    host_rd_n = 1'b0;
    for (n = 0; n < 12 && host_d_oe !== 1'b1; n++) step(1);
    tmo(n);
    chk(host_rd_stb, 1'b1);
    step(1);
    chk(host_d_out, 16'h7e81);
    chk(host_rd_stb, 1'b0);
    host_ce_n = 1'b1;
    host_rd_n = 1'b1;
    for (n = 0; n < 12 && host_d_oe !== 1'b0; n++) step(1);
    tmo(n);
    chip_reset_n = 1'b0;
    step(4);
    chk(chip_reset_req, 1'b1);
    chip_reset_n = 1'b1;
    step(4);
    chk(chip_reset_req, 1'b0);
  endtask : t_host

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    step(6);
    sys_rst = 1'b0;
    step(3);
    t_serial();
    t_parallel();
    t_gain_test();
    t_inputs();
    t_host();
    complete_run();
  end
endmodule : rpfm_top_tb_top
